// ==== core/single_operand_regs.vh ====
// Register offsets, field positions, reset values and operation codes of the single-operand execute block
`ifndef SINGLE_OPERAND_REGS_VH
`define SINGLE_OPERAND_REGS_VH

// Byte offsets on the AXI4-Lite register bus
`define OFS_EXEC        12'h000
`define OFS_WORK        12'h004
`define OFS_STATUS      12'h008
`define OFS_CTRL        12'h00C
`define OFS_FILE_BASE   4'h1
`define OFS_ADDR_BITS   12

// Instruction register fields
`define EXEC_OP_LSB     0
`define EXEC_OP_MSB     2
`define EXEC_DEST_BIT   3
`define EXEC_FILE_LSB   8
`define EXEC_FILE_MSB   13

// Status register fields
`define STAT_NIL_BIT    0
`define STAT_CARRY_BIT  1
`define STAT_SLEEP_BIT  2
`define STAT_EXPIRY_BIT 3

// Control register fields
`define CTRL_DIV_WATCHDOG_BIT 0

// Operation codes
`define OPC_NONE        3'h0
`define OPC_ZERO_WORK   3'h1
`define OPC_KICK_WATCHDOG 3'h2
`define OPC_ZERO_FILE   3'h3
`define OPC_INVERT_FILE 3'h4
`define OPC_COMPARE     3'h5
`define OPC_DECREMENT   3'h6

// Reset values
`define RST_BYTE        8'h00
`define RST_FLAG        1'b0
`define RST_FLAG_N      1'b1
`define ZERO_BYTE       8'h00
`define ONE_BYTE        8'h01

// AXI responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ==== core/single_operand_alu.v ====
// Combinational result and flag logic for the six single-operand operations
`timescale 1ns/1ps
`include "single_operand_regs.vh"

module single_operand_alu
(
  // Decoded instruction
  input  wire [2:0] op,
  input  wire       dest_sel,
  // Operand values
  input  wire [7:0] file_value,
  input  wire [7:0] work_value,
  // Results
  output reg  [7:0] result,
  output reg        write_work,
  output reg        write_file,
  output reg        update_nil,
  output reg        nil_value,
  output reg        update_carry,
  output reg        carry_value,
  output reg        kick
);

  wire [8:0] diff;
  assign diff = {1'b0, file_value} + {1'b0, ~work_value} + 9'h001;

  always @*
  begin
    result       = `ZERO_BYTE;
    write_work   = 1'b0;
    write_file   = 1'b0;
    update_nil   = 1'b0;
    nil_value    = 1'b0;
    update_carry = 1'b0;
    carry_value  = 1'b0;
    kick         = 1'b0;
    case (op)
      `OPC_ZERO_WORK:
      begin
        result     = `ZERO_BYTE;
        write_work = 1'b1;
        update_nil = 1'b1;
        nil_value  = 1'b1;
      end
      `OPC_KICK_WATCHDOG:
      begin
        kick = 1'b1;
      end
      `OPC_ZERO_FILE:
      begin
        result     = `ZERO_BYTE;
        write_file = 1'b1;
        update_nil = 1'b1;
        nil_value  = 1'b1;
      end
      `OPC_INVERT_FILE:
      begin
        result     = ~file_value;
        write_work = ~dest_sel;
        write_file = dest_sel;
        update_nil = 1'b1;
        nil_value  = (result == `ZERO_BYTE);
      end
      `OPC_COMPARE:
      begin
        // Difference is discarded; nothing is written back
        result       = diff[7:0];
        update_nil   = 1'b1;
        nil_value    = (diff[7:0] == `ZERO_BYTE);
        update_carry = 1'b1;
        carry_value  = diff[8];
      end
      `OPC_DECREMENT:
      begin
        result     = file_value - `ONE_BYTE;
        write_work = ~dest_sel;
        write_file = dest_sel;
        update_nil = 1'b1;
        nil_value  = (result == `ZERO_BYTE);
      end
      default:
      begin
        result = `ZERO_BYTE;
      end
    endcase
  end

endmodule // single_operand_alu

// ==== core/single_operand_exec.v ====
// Execute stage for the clear, invert, compare, decrement and watchdog-kick operations with an AXI4-Lite slave
// Behaviour
// - Zero working register sets nil flag
// - Kick clears watchdog counter, divider if assigned
// - Kick sets both watchdog status flags, one cycle
// - Zero file register sets nil flag, one cycle
// - Invert file register, nil flag from result
// - Destination bit selects working or file register
// - Compare subtracts working from file, sets flags
// - Compare stores nothing, one cycle
// - Decrement file register, routed, nil flag updated
`timescale 1ns/1ps
`include "single_operand_regs.vh"

module single_operand_exec
#(
  parameter FILE_ADDR_W = 6
)
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Watchdog side
  input  wire        watchdog_expired,
  input  wire        sleep_entered,
  output wire        watchdog_counter_clear,
  output wire        watchdog_divider_clear
);

  localparam FILE_DEPTH = 1 << FILE_ADDR_W;

  // Bus holding state
  reg                   aw_full_reg;
  reg  [11:0]           aw_addr_reg;
  reg                   w_full_reg;
  reg  [31:0]           w_data_reg;
  reg  [3:0]            w_strb_reg;
  reg                   bvalid_reg;
  reg  [1:0]            bresp_reg;
  reg                   rvalid_reg;
  reg  [1:0]            rresp_reg;
  reg  [31:0]           rdata_reg;

  // Architectural state
  reg  [7:0]            working_register_reg;
  reg  [7:0]            file_reg [0:FILE_DEPTH-1];
  reg                   nil_result_flag_reg;
  reg                   borrow_free_flag_reg;
  reg                   watchdog_expiry_flag_n_reg;
  reg                   sleep_entry_flag_n_reg;
  reg                   divider_on_watchdog_reg;
  reg                   counter_clear_reg;
  reg                   divider_clear_reg;

  // Pending instruction
  reg                   inst_valid_reg;
  reg  [2:0]            inst_op_reg;
  reg                   inst_dest_reg;
  reg  [FILE_ADDR_W-1:0] inst_file_reg;

  wire                  do_write;
  wire                  do_read;
  wire [11:0]           wa;
  wire [11:0]           ra;
  wire                  wa_file;
  wire                  ra_file;
  wire [FILE_ADDR_W-1:0] wa_index;
  wire [FILE_ADDR_W-1:0] ra_index;
  wire                  wa_known;
  wire                  ra_known;
  wire                  exec_write;

  wire [7:0]            alu_result;
  wire                  alu_write_work;
  wire                  alu_write_file;
  wire                  alu_update_nil;
  wire                  alu_nil;
  wire                  alu_update_carry;
  wire                  alu_carry;
  wire                  alu_kick;
  wire                  run_write_work;
  wire                  run_write_file;
  wire                  run_kick;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign watchdog_counter_clear = counter_clear_reg;
  assign watchdog_divider_clear = divider_clear_reg;

  // Write happens once address and data are both held and the last response is gone
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign do_read  = s_axi_arvalid & ~rvalid_reg;
  assign wa       = aw_addr_reg;
  assign ra       = s_axi_araddr;
  assign wa_file  = (wa[11:8] == `OFS_FILE_BASE) & (wa[1:0] == 2'b00);
  assign ra_file  = (ra[11:8] == `OFS_FILE_BASE) & (ra[1:0] == 2'b00);
  assign wa_index = wa[FILE_ADDR_W+1:2];
  assign ra_index = ra[FILE_ADDR_W+1:2];
  assign wa_known = wa_file | (wa == `OFS_EXEC) | (wa == `OFS_WORK) | (wa == `OFS_STATUS) | (wa == `OFS_CTRL);
  assign ra_known = ra_file | (ra == `OFS_EXEC) | (ra == `OFS_WORK) | (ra == `OFS_STATUS) | (ra == `OFS_CTRL);
  assign exec_write = do_write & (wa == `OFS_EXEC) & w_strb_reg[0];

  single_operand_alu i_single_operand_alu
  (
    .op           (inst_op_reg),
    .dest_sel     (inst_dest_reg),
    .file_value   (file_reg[inst_file_reg]),
    .work_value   (working_register_reg),
    .result       (alu_result),
    .write_work   (alu_write_work),
    .write_file   (alu_write_file),
    .update_nil   (alu_update_nil),
    .nil_value    (alu_nil),
    .update_carry (alu_update_carry),
    .carry_value  (alu_carry),
    .kick         (alu_kick)
  );

  assign run_write_work = inst_valid_reg & alu_write_work;
  assign run_write_file = inst_valid_reg & alu_write_file;
  assign run_kick       = inst_valid_reg & alu_kick;

  // Write channel capture and response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & ~aw_full_reg)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_write)
      begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid & ~w_full_reg)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (do_write)
      begin
        w_full_reg <= 1'b0;
      end
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wa_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end
    else if (do_read)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= ra_known ? `RESP_OKAY : `RESP_SLVERR;
      if (ra_file)
        rdata_reg <= {24'h00_0000, file_reg[ra_index]};
      else if (ra == `OFS_EXEC)
        rdata_reg <= {18'h0_0000, inst_file_reg, 4'h0, inst_dest_reg, inst_op_reg};
      else if (ra == `OFS_WORK)
        rdata_reg <= {24'h00_0000, working_register_reg};
      else if (ra == `OFS_STATUS)
        rdata_reg <= {28'h000_0000, watchdog_expiry_flag_n_reg, sleep_entry_flag_n_reg,
                      borrow_free_flag_reg, nil_result_flag_reg};
      else if (ra == `OFS_CTRL)
        rdata_reg <= {31'h0000_0000, divider_on_watchdog_reg};
      else
        rdata_reg <= 32'h0000_0000;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // Instruction issue: a write to the instruction register runs on the next edge
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      inst_valid_reg <= 1'b0;
      inst_op_reg    <= `OPC_NONE;
      inst_dest_reg  <= 1'b0;
      inst_file_reg  <= {FILE_ADDR_W{1'b0}};
    end
    else
    begin
      inst_valid_reg <= exec_write;
      if (exec_write)
      begin
        inst_op_reg   <= w_data_reg[`EXEC_OP_MSB:`EXEC_OP_LSB];
        inst_dest_reg <= w_data_reg[`EXEC_DEST_BIT];
        inst_file_reg <= w_data_reg[`EXEC_FILE_LSB+FILE_ADDR_W-1:`EXEC_FILE_LSB];
      end
    end
  end

  // Working register, flags and control
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      working_register_reg       <= `RST_BYTE;
      nil_result_flag_reg        <= `RST_FLAG;
      borrow_free_flag_reg       <= `RST_FLAG;
      watchdog_expiry_flag_n_reg <= `RST_FLAG_N;
      sleep_entry_flag_n_reg     <= `RST_FLAG_N;
      divider_on_watchdog_reg    <= `RST_FLAG;
      counter_clear_reg          <= 1'b0;
      divider_clear_reg          <= 1'b0;
    end
    else
    begin
      if (run_write_work)
        working_register_reg <= alu_result;
      else if (do_write & (wa == `OFS_WORK) & w_strb_reg[0])
        working_register_reg <= w_data_reg[7:0];
      if (inst_valid_reg & alu_update_nil)
        nil_result_flag_reg <= alu_nil;
      if (inst_valid_reg & alu_update_carry)
        borrow_free_flag_reg <= alu_carry;
      // A timeout or sleep event in the kick cycle wins over the kick
      if (watchdog_expired)
        watchdog_expiry_flag_n_reg <= 1'b0;
      else if (run_kick)
        watchdog_expiry_flag_n_reg <= 1'b1;
      if (sleep_entered)
        sleep_entry_flag_n_reg <= 1'b0;
      else if (run_kick)
        sleep_entry_flag_n_reg <= 1'b1;
      if (do_write & (wa == `OFS_CTRL) & w_strb_reg[0])
        divider_on_watchdog_reg <= w_data_reg[`CTRL_DIV_WATCHDOG_BIT];
      counter_clear_reg <= run_kick;
      divider_clear_reg <= run_kick & divider_on_watchdog_reg;
    end
  end

  // File registers, one write port per entry
  genvar gi;
  generate
    for (gi = 0; gi < FILE_DEPTH; gi = gi + 1)
    begin : g_file
      always @(posedge aclk)
      begin
        if (!aresetn)
          file_reg[gi] <= `RST_BYTE;
        else if (run_write_file & ({{(32-FILE_ADDR_W){1'b0}}, inst_file_reg} == gi))
          file_reg[gi] <= alu_result;
        else if (do_write & wa_file & w_strb_reg[0] & ({{(32-FILE_ADDR_W){1'b0}}, wa_index} == gi))
          file_reg[gi] <= w_data_reg[7:0];
      end
    end
  endgenerate

endmodule // single_operand_exec

// ==== tb/single_operand_exec_props.sv ====
// Checker for bus handshakes, address decode and watchdog clear pulses of the execute block
`timescale 1ns/1ps
`include "single_operand_regs.vh"

module single_operand_exec_chk
#(
  parameter FILE_ADDR_W = 6
)
(
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Write channels
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Read channels
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Watchdog pulses
  input wire        watchdog_counter_clear,
  input wire        watchdog_divider_clear
);
  localparam [11:0] FILE_END = 12'h100 + (4 << FILE_ADDR_W);
  reg  [11:0] wa_reg;
  reg  [31:0] wd_reg;
  reg         ws_reg;
  reg         bv_reg;
  reg         ctrl_reg;
  wire        done_now  = s_axi_bvalid && !bv_reg;
  wire        exec_kick = done_now && wa_reg == `OFS_EXEC && ws_reg && wd_reg[2:0] == `OPC_KICK_WATCHDOG;
  wire        rd_take   = s_axi_arvalid && s_axi_arready;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Remembers the last write so its effect can be predicted when its response rises
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wa_reg   <= 12'h000;
      wd_reg   <= 32'h0000_0000;
      ws_reg   <= 1'b0;
      bv_reg   <= 1'b0;
      ctrl_reg <= 1'b0;
    end
    else
    begin
      bv_reg <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
        wa_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb[0];
      end
      if (done_now && wa_reg == `OFS_CTRL && ws_reg)
        ctrl_reg <= wd_reg[0];
    end
  end

  kick_pulse_a : assert property (exec_kick |=> watchdog_counter_clear)
    else $error("kick gave no counter clear pulse");
  clear_cause_a : assert property (watchdog_counter_clear |-> $past(exec_kick))
    else $error("counter clear pulse without a kick");
  div_follow_a : assert property (exec_kick |=> watchdog_divider_clear == $past(ctrl_reg))
    else $error("divider clear does not follow its assignment");
  div_with_a : assert property (watchdog_divider_clear |-> watchdog_counter_clear)
    else $error("divider clear without counter clear");
  unmapped_rd_a : assert property (rd_take && s_axi_araddr >= FILE_END
    |=> s_axi_rvalid && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("read past the file registers not refused");
  file_rd_a : assert property (rd_take && s_axi_araddr >= 12'h100 && s_axi_araddr < FILE_END
    && s_axi_araddr[1:0] == 2'b00 |=> s_axi_rresp == `RESP_OKAY)
    else $error("file register read refused");
  wr_answer_a : assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  resp_clear_a : assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated after its handshake");
  bvalid_hold_a : assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a : assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  kick_div_c : cover property (exec_kick ##1 watchdog_divider_clear);
  slverr_c : cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
  bstall_c : cover property (s_axi_bvalid && !s_axi_bready);
endmodule // single_operand_exec_chk

bind single_operand_exec single_operand_exec_chk #(.FILE_ADDR_W(FILE_ADDR_W)) i_single_operand_exec_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .watchdog_counter_clear(watchdog_counter_clear), .watchdog_divider_clear(watchdog_divider_clear));

// ==== tb/testbench.sv ====
// Self-checking testbench for the single-operand execute block
`timescale 1ns/1ps
`include "single_operand_regs.vh"

module testbench;
  localparam [31:0] WORKS = 32'h34F0_3512;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         watchdog_expired, sleep_entered;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        watchdog_counter_clear, watchdog_divider_clear;
  integer     bad_count, checks_done, cycles, i;
  reg  [33:0] n_cnt, n_div;
  reg  [7:0]  w;

  single_operand_exec #(.FILE_ADDR_W(6)) i_single_operand_exec (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .watchdog_expired(watchdog_expired), .sleep_entered(sleep_entered),
    .watchdog_counter_clear(watchdog_counter_clear), .watchdog_divider_clear(watchdog_divider_clear));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  task check(input [33:0] seen, input [33:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Response is accepted one cycle late so the slave must hold it
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    reg aw_ok, w_ok;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok))
      begin
        @(posedge aclk);
        if (!aw_ok && s_axi_awready === 1'b1)
        begin
          aw_ok = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_ok && s_axi_wready === 1'b1)
        begin
          w_ok = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (s_axi_bvalid !== 1'b1)
        @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      check({32'h0000_0000, s_axi_bresp}, {32'h0000_0000, er});
      s_axi_bready <= 1'b0;
    end
  endtask

  task rd(input [11:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge aclk);
      while (s_axi_arready !== 1'b1)
        @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (s_axi_rvalid !== 1'b1)
        @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      check({s_axi_rresp, s_axi_rdata}, {er, ed});
      s_axi_rready <= 1'b0;
    end
  endtask

  task op(input [2:0] o, input d, input [5:0] f);
    wr(`OFS_EXEC, {18'h0_0000, f, 4'h0, d, o}, `RESP_OKAY);
  endtask

  function [11:0] fa(input [5:0] n);
    fa = 12'h100 + {4'h0, n, 2'b00};
  endfunction

  task pulse(input e, input s);
    begin
      @(posedge aclk);
      watchdog_expired <= e;
      sleep_entered <= s;
      @(posedge aclk);
      watchdog_expired <= 1'b0;
      sleep_entered <= 1'b0;
    end
  endtask

  always @(posedge aclk)
  begin
    cycles = cycles + 1;
    if (watchdog_counter_clear === 1'b1)
      n_cnt = n_cnt + 1;
    if (watchdog_divider_clear === 1'b1)
      n_div = n_div + 1;
    if (cycles == 4000)
    begin
      bad_count = bad_count + 1;
      close_out;
    end
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {watchdog_expired, sleep_entered, aresetn} = 3'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {bad_count, checks_done, cycles} = 96'h0;
    n_cnt = 34'h0_0000_0000;
    n_div = 34'h0_0000_0000;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_WORK, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_000C, `RESP_OKAY);
    rd(`OFS_CTRL, 32'h0000_0000, `RESP_OKAY);
    rd(12'h010, 32'h0000_0000, `RESP_SLVERR);
    rd(12'h200, 32'h0000_0000, `RESP_SLVERR);
    wr(12'h200, 32'h0000_0001, `RESP_SLVERR);
    wr(fa(7), 32'h0000_00A6, `RESP_OKAY);
    op(`OPC_INVERT_FILE, 1'b1, 6'd7);
    rd(fa(7), 32'h0000_0059, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_000C, `RESP_OKAY);
    op(`OPC_INVERT_FILE, 1'b0, 6'd7);
    rd(`OFS_WORK, 32'h0000_00A6, `RESP_OKAY);
    rd(fa(7), 32'h0000_0059, `RESP_OKAY);
    op(`OPC_ZERO_WORK, 1'b0, 6'd0);
    rd(`OFS_WORK, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_000D, `RESP_OKAY);
    wr(fa(8), 32'h0000_0002, `RESP_OKAY);
    op(`OPC_DECREMENT, 1'b1, 6'd8);
    rd(fa(8), 32'h0000_0001, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_000C, `RESP_OKAY);
    op(`OPC_DECREMENT, 1'b0, 6'd8);
    rd(`OFS_WORK, 32'h0000_0000, `RESP_OKAY);
    rd(fa(8), 32'h0000_0001, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_000D, `RESP_OKAY);
    wr(fa(62), 32'h0000_0077, `RESP_OKAY);
    op(`OPC_INVERT_FILE, 1'b1, 6'd63);
    rd(fa(63), 32'h0000_00FF, `RESP_OKAY);
    op(`OPC_ZERO_FILE, 1'b0, 6'd63);
    rd(fa(63), 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_000D, `RESP_OKAY);
    rd(fa(62), 32'h0000_0077, `RESP_OKAY);
    wr(fa(9), 32'h0000_0034, `RESP_OKAY);
    for (i = 0; i < 4; i = i + 1)
    begin
      w = WORKS[8 * i +: 8];
      wr(`OFS_WORK, {24'h00_0000, w}, `RESP_OKAY);
      op(`OPC_COMPARE, i[0], 6'd9);
      rd(`OFS_STATUS, {28'h000_0000, 2'b11, 8'h34 >= w, 8'h34 == w}, `RESP_OKAY);
      rd(`OFS_WORK, {24'h00_0000, w}, `RESP_OKAY);
      rd(fa(9), 32'h0000_0034, `RESP_OKAY);
    end
    pulse(1'b1, 1'b1);
    rd(`OFS_STATUS, 32'h0000_0003, `RESP_OKAY);
    op(`OPC_KICK_WATCHDOG, 1'b0, 6'd0);
    rd(`OFS_STATUS, 32'h0000_000F, `RESP_OKAY);
    wr(`OFS_CTRL, 32'h0000_0001, `RESP_OKAY);
    rd(`OFS_CTRL, 32'h0000_0001, `RESP_OKAY);
    pulse(1'b1, 1'b0);
    rd(`OFS_STATUS, 32'h0000_0007, `RESP_OKAY);
    op(`OPC_KICK_WATCHDOG, 1'b0, 6'd0);
    rd(`OFS_STATUS, 32'h0000_000F, `RESP_OKAY);
    check(n_cnt, 34'h0_0000_0002);
    check(n_div, 34'h0_0000_0001);
    close_out;
  end
endmodule // testbench
